// file: ccad_defs.vh
// constants for the jump condition and add decode block
`ifndef CCAD_DEFS_VH
`define CCAD_DEFS_VH
`define CCAD_FLAG_C 7
`define CCAD_FLAG_Z 6
`define CCAD_FLAG_S 5
`define CCAD_FLAG_V 4
`define CCAD_FLAG_D 3
`define CCAD_FLAG_H 2
`define CCAD_FLAGS_RESET 8'h00
`define CCAD_PC_RESET 16'h0000
`define CCAD_CC_NEVER 4'h0
`define CCAD_CC_SIGNED_BELOW 4'h1
`define CCAD_CC_SIGNED_AT_MOST 4'h2
`define CCAD_CC_UNSIGNED_AT_MOST 4'h3
`define CCAD_CC_EXCESS_SET 4'h4
`define CCAD_CC_NEGATIVE_SIGN 4'h5
`define CCAD_CC_ZERO_SET 4'h6
`define CCAD_CC_CARRY_SET 4'h7
`define CCAD_CC_ALWAYS 4'h8
`define CCAD_CC_SIGNED_AT_LEAST 4'h9
`define CCAD_CC_SIGNED_ABOVE 4'ha
`define CCAD_CC_UNSIGNED_ABOVE 4'hb
`define CCAD_CC_EXCESS_CLEAR 4'hc
`define CCAD_CC_SIGN_CLEAR 4'hd
`define CCAD_CC_ZERO_CLEAR 4'he
`define CCAD_CC_CARRY_CLEAR 4'hf
`define CCAD_OP_NONE 3'h0
`define CCAD_OP_ADD 3'h1
`define CCAD_OP_ADC 3'h2
`define CCAD_OP_JUMP 3'h3
`define CCAD_OP_REL 3'h4
`define CCAD_MODE_REG 3'h0
`define CCAD_MODE_WORK 3'h1
`define CCAD_MODE_PAIR 3'h2
`define CCAD_MODE_WPAIR 3'h3
`define CCAD_MODE_XSHORT 3'h4
`define CCAD_MODE_XLONG 3'h5
`define CCAD_MODE_DIRECT 3'h6
`define CCAD_MODE_IMM 3'h7
`endif

// file: ccad_regfile.v
// small register file holding working register pairs for index addressing
module ccad_regfile (
    core_clk,
    rst_sync_n,
    wr_en,
    wr_idx,
    wr_data,
    rd_idx,
    rd_data
);
    input wire core_clk;
    input wire rst_sync_n;
    input wire wr_en;
    input wire [3:0] wr_idx;
    input wire [7:0] wr_data;
    input wire [3:0] rd_idx;
    output reg [15:0] rd_data;

    reg [7:0] mem [0:15];
    integer i;

    // pair read: even index is high byte, odd index low byte
    always @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_data <= 16'h0000;
            for (i = 0; i < 16; i = i + 1) begin
                mem[i] <= 8'h00;
            end
        end else begin
            if (wr_en) begin
                mem[wr_idx] <= wr_data;
            end
            rd_data <= {mem[{rd_idx[3:1], 1'b0}], mem[{rd_idx[3:1], 1'b1}]};
        end
    end
endmodule

// file: ccad_core.v
// jump condition evaluation, add execution and operand address forming
`include "ccad_defs.vh"
module ccad_core (
    core_clk,
    rst_n,
    op_valid,
    op_kind,
    jump_condition_field,
    dst_data,
    src_data,
    instr_len,
    rel_disp,
    op_mode,
    op_reg_addr,
    op_work_idx,
    op_bit_sel,
    op_disp16,
    op_imm16,
    wr_work_en,
    wr_work_idx,
    wr_work_data,
    flags_load_en,
    flags_load_val,
    pc_load_en,
    pc_load_val,
    result_reg,
    result_wr_reg,
    flags_reg,
    pc_reg,
    jump_taken_reg,
    addr_reg,
    addr_valid_reg,
    bit_mask_reg,
    operand_ok_reg
);
    input wire core_clk;
    input wire rst_n;
    input wire op_valid;
    input wire [2:0] op_kind;
    input wire [3:0] jump_condition_field;
    input wire [7:0] dst_data;
    input wire [7:0] src_data;
    input wire [1:0] instr_len;
    input wire [7:0] rel_disp;
    input wire [2:0] op_mode;
    input wire [7:0] op_reg_addr;
    input wire [3:0] op_work_idx;
    input wire [2:0] op_bit_sel;
    input wire [15:0] op_disp16;
    input wire [15:0] op_imm16;
    input wire wr_work_en;
    input wire [3:0] wr_work_idx;
    input wire [7:0] wr_work_data;
    input wire flags_load_en;
    input wire [7:0] flags_load_val;
    input wire pc_load_en;
    input wire [15:0] pc_load_val;
    output reg [7:0] result_reg;
    output reg result_wr_reg;
    output reg [7:0] flags_reg;
    output reg [15:0] pc_reg;
    output reg jump_taken_reg;
    output reg [15:0] addr_reg;
    output reg addr_valid_reg;
    output reg [7:0] bit_mask_reg;
    output reg operand_ok_reg;

    localparam ST_IDLE = 3'b001;
    localparam ST_FETCH = 3'b010;
    localparam ST_FORM = 3'b100;

    reg rst_meta_reg;
    reg rst_sync_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [2:0] mode_hold_reg;
    reg [15:0] disp_hold_reg;
    reg [3:0] idx_hold_reg;
    wire [15:0] pair_data;
    wire [3:0] pair_idx;

    // held index while forming, so a changed index input cannot spoil the pair read
    assign pair_idx = (state_reg == ST_IDLE) ? op_work_idx : idx_hold_reg;

    // condition decode over the four testable flags
    function cond_true;
        input [3:0] code;
        input c;
        input z;
        input s;
        input v;
        reg lt;
        begin
            lt = s ^ v;
            case (code)
                `CCAD_CC_NEVER: cond_true = 1'b0;
                `CCAD_CC_ALWAYS: cond_true = 1'b1;
                `CCAD_CC_CARRY_SET: cond_true = c;
                `CCAD_CC_CARRY_CLEAR: cond_true = ~c;
                `CCAD_CC_ZERO_SET: cond_true = z;
                `CCAD_CC_ZERO_CLEAR: cond_true = ~z;
                `CCAD_CC_NEGATIVE_SIGN: cond_true = s;
                `CCAD_CC_SIGN_CLEAR: cond_true = ~s;
                `CCAD_CC_EXCESS_SET: cond_true = v;
                `CCAD_CC_EXCESS_CLEAR: cond_true = ~v;
                `CCAD_CC_SIGNED_AT_LEAST: cond_true = ~lt;
                `CCAD_CC_SIGNED_BELOW: cond_true = lt;
                `CCAD_CC_SIGNED_ABOVE: cond_true = ~(z | lt);
                `CCAD_CC_SIGNED_AT_MOST: cond_true = z | lt;
                `CCAD_CC_UNSIGNED_ABOVE: cond_true = ~c & ~z;
                `CCAD_CC_UNSIGNED_AT_MOST: cond_true = c | z;
                default: cond_true = 1'b0;
            endcase
        end
    endfunction

    function [15:0] sext8;
        input [7:0] b;
        begin
            sext8 = {{8{b[7]}}, b};
        end
    endfunction

    // add datapath shared by both add forms
    reg [8:0] sum9;
    reg [4:0] low5;
    reg carry_in;
    reg [7:0] flags_add;
    always @* begin
        carry_in = (op_kind == `CCAD_OP_ADC) ? flags_reg[`CCAD_FLAG_C] : 1'b0;
        sum9 = {1'b0, dst_data} + {1'b0, src_data} + {8'h00, carry_in};
        low5 = {1'b0, dst_data[3:0]} + {1'b0, src_data[3:0]} + {4'h0, carry_in};
        flags_add = flags_reg;
        flags_add[`CCAD_FLAG_C] = sum9[8];
        flags_add[`CCAD_FLAG_Z] = (sum9[7:0] == 8'h00);
        flags_add[`CCAD_FLAG_S] = sum9[7];
        flags_add[`CCAD_FLAG_V] = (dst_data[7] == src_data[7]) &&
            (sum9[7] != dst_data[7]);
        flags_add[`CCAD_FLAG_D] = 1'b0;
        flags_add[`CCAD_FLAG_H] = low5[4];
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    ccad_regfile u_regfile (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_reg),
        .wr_en(wr_work_en),
        .wr_idx(wr_work_idx),
        .wr_data(wr_work_data),
        .rd_idx(pair_idx),
        .rd_data(pair_data)
    );

    // execute: add, jump decision, pc update
    always @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            result_reg <= 8'h00;
            result_wr_reg <= 1'b0;
            flags_reg <= `CCAD_FLAGS_RESET;
            pc_reg <= `CCAD_PC_RESET;
            jump_taken_reg <= 1'b0;
        end else begin
            result_wr_reg <= 1'b0;
            jump_taken_reg <= 1'b0;
            if (flags_load_en) begin
                flags_reg <= flags_load_val;
            end
            if (pc_load_en) begin
                pc_reg <= pc_load_val;
            end else if (op_valid) begin
                case (op_kind)
                    `CCAD_OP_ADD, `CCAD_OP_ADC: begin
                        result_reg <= sum9[7:0];
                        result_wr_reg <= 1'b1;
                        flags_reg <= flags_add;
                        pc_reg <= pc_reg + {14'h0000, instr_len};
                    end
                    `CCAD_OP_JUMP: begin
                        // absolute target comes on op_disp16
                        if (cond_true(jump_condition_field, flags_reg[`CCAD_FLAG_C],
                                flags_reg[`CCAD_FLAG_Z], flags_reg[`CCAD_FLAG_S],
                                flags_reg[`CCAD_FLAG_V])) begin
                            pc_reg <= op_disp16;
                            jump_taken_reg <= 1'b1;
                        end else begin
                            pc_reg <= pc_reg + {14'h0000, instr_len};
                        end
                    end
                    `CCAD_OP_REL: begin
                        if (cond_true(jump_condition_field, flags_reg[`CCAD_FLAG_C],
                                flags_reg[`CCAD_FLAG_Z], flags_reg[`CCAD_FLAG_S],
                                flags_reg[`CCAD_FLAG_V])) begin
                            pc_reg <= pc_reg + {14'h0000, instr_len} +
                                sext8(rel_disp);
                            jump_taken_reg <= 1'b1;
                        end else begin
                            pc_reg <= pc_reg + {14'h0000, instr_len};
                        end
                    end
                    default: begin
                        pc_reg <= pc_reg;
                    end
                endcase
            end
        end
    end

    // operand address forming; indexed modes wait two extra cycles for the pair read
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (op_valid) begin
                    state_next = ((op_mode == `CCAD_MODE_XSHORT) ||
                        (op_mode == `CCAD_MODE_XLONG)) ? ST_FETCH : ST_IDLE;
                end
            end
            ST_FETCH: state_next = ST_FORM;
            ST_FORM: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= ST_IDLE;
            mode_hold_reg <= `CCAD_MODE_REG;
            disp_hold_reg <= 16'h0000;
            idx_hold_reg <= 4'h0;
            addr_reg <= 16'h0000;
            addr_valid_reg <= 1'b0;
            bit_mask_reg <= 8'h00;
            operand_ok_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_valid_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (op_valid) begin
                        mode_hold_reg <= op_mode;
                        disp_hold_reg <= op_disp16;
                        idx_hold_reg <= op_work_idx;
                        bit_mask_reg <= 8'h01 << op_bit_sel;
                        case (op_mode)
                            `CCAD_MODE_REG: begin
                                addr_reg <= {8'h00, op_reg_addr};
                                operand_ok_reg <= 1'b1;
                            end
                            `CCAD_MODE_WORK: begin
                                addr_reg <= {12'h000, op_work_idx};
                                operand_ok_reg <= 1'b1;
                            end
                            `CCAD_MODE_PAIR: begin
                                addr_reg <= {8'h00, op_reg_addr};
                                operand_ok_reg <= ~op_reg_addr[0];
                            end
                            `CCAD_MODE_WPAIR: begin
                                addr_reg <= {12'h000, op_work_idx};
                                operand_ok_reg <= ~op_work_idx[0];
                            end
                            `CCAD_MODE_DIRECT: begin
                                addr_reg <= op_disp16;
                                operand_ok_reg <= 1'b1;
                            end
                            `CCAD_MODE_IMM: begin
                                addr_reg <= op_imm16;
                                operand_ok_reg <= 1'b1;
                            end
                            default: begin
                                operand_ok_reg <= ~op_work_idx[0];
                            end
                        endcase
                        addr_valid_reg <= (state_next == ST_IDLE);
                    end
                end
                ST_FORM: begin
                    if (mode_hold_reg == `CCAD_MODE_XSHORT) begin
                        addr_reg <= pair_data + sext8(disp_hold_reg[7:0]);
                    end else begin
                        addr_reg <= pair_data + disp_hold_reg;
                    end
                    addr_valid_reg <= 1'b1;
                end
                default: begin
                    addr_valid_reg <= 1'b0;
                end
            endcase
        end
    end
endmodule

// file: ccad_core_sva.sv
// concurrent checks on the ports of the jump condition and add decode core
module ccad_core_sva (
    input logic core_clk,
    input logic rst_n,
    input logic op_valid,
    input logic [2:0] op_kind,
    input logic [3:0] jump_condition_field,
    input logic [7:0] dst_data,
    input logic [7:0] src_data,
    input logic [1:0] instr_len,
    input logic [7:0] rel_disp,
    input logic [2:0] op_mode,
    input logic [15:0] op_disp16,
    input logic pc_load_en,
    input logic flags_load_en,
    input logic [7:0] result_reg,
    input logic result_wr_reg,
    input logic [7:0] flags_reg,
    input logic [15:0] pc_reg,
    input logic jump_taken_reg,
    input logic [15:0] addr_reg,
    input logic addr_valid_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    wire cin = op_kind == 3'h2 && flags_reg[7];
    wire [8:0] sum = {1'b0, dst_data} + {1'b0, src_data} + {8'h00, cin};
    wire [7:0] res = sum[7:0];
    wire cout = sum[8];
    wire hc = ({1'b0, dst_data[3:0]} + {1'b0, src_data[3:0]} + {4'h0, cin}) > 5'h0f;
    wire ovf = dst_data[7] == src_data[7] && res[7] != dst_data[7];
    wire sx = flags_reg[5] ^ flags_reg[4];
    // code bit 3 inverts the test picked by bits 2:0
    wire [7:0] tv = {flags_reg[7:4], flags_reg[7] | flags_reg[6], flags_reg[6] | sx, sx, 1'b0};
    wire take = tv[jump_condition_field[2:0]] ^ jump_condition_field[3];
    wire [15:0] pc_seq = pc_reg + {14'h0000, instr_len};
    wire [15:0] rel_t = pc_seq + {{8{rel_disp[7]}}, rel_disp};
    wire [15:0] jt = !take ? pc_seq : (op_kind == 3'h3 ? op_disp16 : rel_t);
    wire add_go = op_valid && !pc_load_en && (op_kind == 3'h1 || op_kind == 3'h2);
    wire jmp_go = op_valid && !pc_load_en && !flags_load_en && (op_kind == 3'h3 || op_kind == 3'h4);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_index_req;
        op_valid && !pc_load_en && (op_mode == 3'h4 || op_mode == 3'h5);
    endsequence
    sequence s_addr_out;
        ##3 addr_valid_reg;
    endsequence
    a_add_sum: assert property (add_go |=> result_wr_reg && result_reg == $past(res))
        else $error("add result wrong");
    a_add_carry: assert property (add_go |=> flags_reg[7] == $past(cout))
        else $error("add carry flag wrong");
    a_add_zero_sign: assert property (add_go |=> flags_reg[6] == (result_reg == 8'h00) && flags_reg[5] == result_reg[7])
        else $error("add zero or sign flag wrong");
    a_add_overflow: assert property (add_go |=> flags_reg[4] == $past(ovf))
        else $error("add overflow flag wrong");
    a_add_dec_clear: assert property (add_go |=> !flags_reg[3])
        else $error("add left decimal flag set");
    a_half_carry: assert property (add_go |=> flags_reg[2] == $past(hc))
        else $error("half carry flag wrong");
    a_jump_decide: assert property (jmp_go |=> jump_taken_reg == $past(take) && $stable(flags_reg))
        else $error("jump decision wrong");
    a_jump_target: assert property (jmp_go |=> pc_reg == $past(jt))
        else $error("pc after jump wrong");
    a_index_latency: assert property (s_index_req |-> s_addr_out)
        else $error("indexed address late");
    a_direct_addr: assert property (op_valid && !pc_load_en && op_mode == 3'h6 |=> addr_valid_reg && addr_reg == $past(op_disp16))
        else $error("direct address wrong");
    a_write_cause: assert property (result_wr_reg |-> $past(add_go))
        else $error("result write without add");
endmodule

bind ccad_core ccad_core_sva u_sva (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_kind(op_kind), .jump_condition_field(jump_condition_field), .dst_data(dst_data),
    .src_data(src_data), .instr_len(instr_len), .rel_disp(rel_disp), .op_mode(op_mode),
    .op_disp16(op_disp16), .pc_load_en(pc_load_en), .flags_load_en(flags_load_en),
    .result_reg(result_reg), .result_wr_reg(result_wr_reg), .flags_reg(flags_reg),
    .pc_reg(pc_reg), .jump_taken_reg(jump_taken_reg), .addr_reg(addr_reg),
    .addr_valid_reg(addr_valid_reg));

// file: ccad_tb.sv
// self-checking bench for the jump condition and add decode core
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [2:0] k; logic [7:0] d, s, f, r, e;} ccad_row_t;
    ccad_row_t rows[8] = '{'{3'h1, 8'h12, 8'h03, 8'h00, 8'h15, 8'h00},
        '{3'h2, 8'h10, 8'h03, 8'h80, 8'h14, 8'h00}, '{3'h1, 8'hff, 8'h01, 8'h08, 8'h00, 8'hc4},
        '{3'h1, 8'h7f, 8'h01, 8'h00, 8'h80, 8'h34}, '{3'h1, 8'h80, 8'h80, 8'h00, 8'h00, 8'hd0},
        '{3'h2, 8'hff, 8'h00, 8'h83, 8'h00, 8'hc7}, '{3'h2, 8'h0f, 8'h00, 8'h08, 8'h0f, 8'h00},
        '{3'h2, 8'h08, 8'h07, 8'h80, 8'h10, 8'h04}};
    logic core_clk, rst_n, op_valid, wr_work_en, flags_load_en, pc_load_en;
    logic [2:0] op_kind, op_mode, op_bit_sel;
    logic [3:0] jump_condition_field, op_work_idx, wr_work_idx;
    logic [7:0] dst_data, src_data, rel_disp, op_reg_addr, wr_work_data, flags_load_val;
    logic [1:0] instr_len;
    logic [15:0] op_disp16, op_imm16, pc_load_val, pc_reg, addr_reg;
    logic [7:0] result_reg, flags_reg, bit_mask_reg;
    logic result_wr_reg, jump_taken_reg, addr_valid_reg, operand_ok_reg;
    int err_total = 0;
    int n_compared = 0;
    logic ex;
    ccad_core DUT (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid), .op_kind(op_kind),
        .jump_condition_field(jump_condition_field), .dst_data(dst_data), .src_data(src_data),
        .instr_len(instr_len), .rel_disp(rel_disp), .op_mode(op_mode), .op_reg_addr(op_reg_addr),
        .op_work_idx(op_work_idx), .op_bit_sel(op_bit_sel), .op_disp16(op_disp16),
        .op_imm16(op_imm16), .wr_work_en(wr_work_en), .wr_work_idx(wr_work_idx),
        .wr_work_data(wr_work_data), .flags_load_en(flags_load_en),
        .flags_load_val(flags_load_val), .pc_load_en(pc_load_en), .pc_load_val(pc_load_val),
        .result_reg(result_reg), .result_wr_reg(result_wr_reg), .flags_reg(flags_reg),
        .pc_reg(pc_reg), .jump_taken_reg(jump_taken_reg), .addr_reg(addr_reg),
        .addr_valid_reg(addr_valid_reg), .bit_mask_reg(bit_mask_reg),
        .operand_ok_reg(operand_ok_reg));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task test_done;
        $display("mismatches %0d of %0d compares", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick;
        @(posedge core_clk);
        #1;
    endtask
    // flags and pc loaded together, no instruction in that cycle
    task prep(input logic [7:0] f, input logic [15:0] p);
        flags_load_en = 1'b1;
        flags_load_val = f;
        pc_load_en = 1'b1;
        pc_load_val = p;
        tick;
        flags_load_en = 1'b0;
        pc_load_en = 1'b0;
    endtask
    task op(input logic [2:0] k, input logic [3:0] c, input logic [7:0] d, input logic [7:0] s);
        op_valid = 1'b1;
        op_kind = k;
        jump_condition_field = c;
        dst_data = d;
        src_data = s;
        tick;
        op_valid = 1'b0;
    endtask
    task wr(input logic [3:0] i, input logic [7:0] v);
        wr_work_en = 1'b1;
        wr_work_idx = i;
        wr_work_data = v;
        tick;
        wr_work_en = 1'b0;
    endtask
    function automatic logic cc_take(input logic [3:0] c, input logic [3:0] f);
        logic [7:0] tv;
        tv = {f, f[3] | f[2], f[2] | (f[1] ^ f[0]), f[1] ^ f[0], 1'b0};
        return tv[c[2:0]] ^ c[3];
    endfunction
    initial begin
        #50us;
        err_total++;
        test_done;
    end
    initial begin
        {op_valid, wr_work_en, flags_load_en, pc_load_en, op_kind, op_mode, op_bit_sel} = '0;
        {jump_condition_field, op_work_idx, wr_work_idx, dst_data, src_data, rel_disp} = '0;
        {op_reg_addr, wr_work_data, flags_load_val, op_imm16, pc_load_val} = '0;
        instr_len = 2'h2;
        op_disp16 = 16'h2468;
        rst_n = 1'b0;
        repeat (10) tick;
        chk({flags_reg, result_reg}, 16'h0000);
        rst_n = 1'b1;
        repeat (5) tick;
        foreach (rows[i]) begin
            prep(rows[i].f, 16'h0040);
            op(rows[i].k, 4'h0, rows[i].d, rows[i].s);
            chk(16'(result_reg), 16'(rows[i].r));
            chk(16'(result_wr_reg), 16'h0001);
            chk(16'(flags_reg), 16'(rows[i].e));
        end
        for (int c = 0; c < 16; c++) begin
            for (int f = 0; f < 16; f++) begin
                prep({f[3:0], 4'h0}, 16'h0100);
                op(3'h3, c[3:0], 8'h00, 8'h00);
                ex = cc_take(c[3:0], f[3:0]);
                chk(16'(jump_taken_reg), 16'(ex));
                chk(pc_reg, ex ? 16'h2468 : 16'h0102);
                chk(16'(flags_reg), {8'h00, f[3:0], 4'h0});
            end
        end
        instr_len = 2'h3;
        rel_disp = 8'h80;
        prep(8'h00, 16'h0100);
        op(3'h4, 4'h8, 8'h00, 8'h00);
        chk(pc_reg, 16'h0083);
        rel_disp = 8'h7f;
        op(3'h4, 4'h8, 8'h00, 8'h00);
        chk(pc_reg, 16'h0105);
        prep(8'h00, 16'h0000);
        op(3'h1, 4'h0, 8'hff, 8'h01);
        op(3'h2, 4'h0, 8'h00, 8'h00);
        chk({flags_reg, result_reg}, 16'h0001);
        wr(4'h2, 8'h12);
        wr(4'h3, 8'h34);
        tick;
        op_work_idx = 4'h2;
        op_mode = 3'h4;
        op_disp16 = 16'h00fe;
        op(3'h0, 4'h0, 8'h00, 8'h00);
        tick;
        chk(16'(addr_valid_reg), 16'h0000);
        tick;
        chk(16'(addr_valid_reg), 16'h0001);
        chk(addr_reg, 16'h1232);
        op_mode = 3'h5;
        op_disp16 = 16'h1000;
        op(3'h0, 4'h0, 8'h00, 8'h00);
        repeat (2) tick;
        chk(addr_reg, 16'h2234);
        op_mode = 3'h6;
        op_disp16 = 16'hbeef;
        op(3'h0, 4'h0, 8'h00, 8'h00);
        chk(addr_reg, 16'hbeef);
        op_mode = 3'h2;
        op_reg_addr = 8'h05;
        op(3'h0, 4'h0, 8'h00, 8'h00);
        chk(16'(operand_ok_reg), 16'h0000);
        op_reg_addr = 8'h04;
        op(3'h0, 4'h0, 8'h00, 8'h00);
        chk(16'(operand_ok_reg), 16'h0001);
        op_mode = 3'h3;
        op_work_idx = 4'h3;
        op(3'h0, 4'h0, 8'h00, 8'h00);
        chk(16'(operand_ok_reg), 16'h0000);
        op_mode = 3'h1;
        op_work_idx = 4'h9;
        op(3'h0, 4'h0, 8'h00, 8'h00);
        chk(addr_reg, 16'h0009);
        chk(16'(operand_ok_reg), 16'h0001);
        op_mode = 3'h7;
        op_imm16 = 16'h5a5a;
        op(3'h0, 4'h0, 8'h00, 8'h00);
        chk(addr_reg, 16'h5a5a);
        op_mode = 3'h0;
        for (int b = 0; b < 8; b++) begin
            op_bit_sel = b[2:0];
            op(3'h0, 4'h0, 8'h00, 8'h00);
            chk(16'(bit_mask_reg), 16'h0001 << b);
        end
        // reset in mid-run clears at once
        rst_n = 1'b0;
        #1;
        chk(pc_reg, 16'h0000);
        tick;
        rst_n = 1'b1;
        repeat (5) tick;
        test_done;
    end
endmodule
